// File: hw/sadc_pkg.sv
// Shared constants and state types for the serial converter link
package sadc_pkg;
    // ------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------
    localparam int MCLK_NS = 100;
    localparam int MCLK_KHZ = 10000;
    localparam int CONV_CLK_KHZ = 400;
    localparam int CONV_HALF = MCLK_KHZ / (2 * CONV_CLK_KHZ);
    localparam int SCK_PERIOD_NS = 800;
    localparam int SCK_HALF = SCK_PERIOD_NS / (2 * MCLK_NS);
    // ------------------------------------------------------------
    // Conversion and port timing
    // ------------------------------------------------------------
    localparam int SAR_BITS = 8;
    localparam int CONV_CLKS = 56;
    localparam int CLK_PER_BIT = CONV_CLKS / SAR_BITS;
    localparam int PORT_DELAY_CLKS = 5;
    localparam int PORT_WAIT_NS = 12500;
    // Doubled to cover conversion clock phase and synchroniser lag
    localparam int PORT_WAIT_CYC = 2 * ((PORT_WAIT_NS + MCLK_NS - 1) / MCLK_NS);
    localparam int CONV_TIME_NS = 140000;
    // Two full conversions so at least one completes
    localparam int CONV_HOLD_CYC = 2 * ((CONV_TIME_NS + MCLK_NS - 1) / MCLK_NS);
    localparam int CNT_W = 12;
    // ------------------------------------------------------------
    // Channels and battery thresholds
    // ------------------------------------------------------------
    localparam int ADDR_BITS = 8;
    localparam logic [1:0] CH_BATTERY = 2'h1;
    localparam logic [7:0] SAR_FIRST = 8'h80;
    localparam logic [7:0] LOW_VOLT_CODE = 8'hd9;
    localparam logic [7:0] RECHARGE_CODE = 8'he6;
    localparam int EFF_LSB = 2;

    typedef enum logic [1:0] {DEV_PORT, DEV_CONV, DEV_DRAIN} sadc_dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_SEL, H_CONV, H_WAIT, H_READ, H_DONE} sadc_host_state_t;
endpackage

// File: hw/sadc_link_if.sv
// Serial select, shift clock, data and conversion clock between the two ends
`timescale 1ns/10ps
interface sadc_link_if;
    logic cs;
    logic sck;
    logic si;
    logic so;
    logic conv_clk;
    modport host (output cs, output sck, output si, output conv_clk, input so);
    modport dev (input cs, input sck, input si, input conv_clk, output so);
endinterface

// File: hw/sadc_sync_edge.sv
// Two-stage synchroniser with edge pulses
`timescale 1ns/10ps
module sadc_sync_edge (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic d_i,
    output logic lvl_o,
    output logic rise_o,
    output logic fall_o
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;

    always_comb begin
        sh_next = {sh_reg[1:0], d_i};
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sh_reg <= 3'h0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    assign lvl_o = sh_reg[1];
    assign rise_o = sh_reg[1] & ~sh_reg[2];
    assign fall_o = ~sh_reg[1] & sh_reg[2];
endmodule

// File: hw/sadc_device_end.sv
// Converter end: channel decode, successive approximation, serial readout
`timescale 1ns/10ps
module sadc_device_end
    import sadc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    sadc_link_if.dev link,
    input wire logic [3:0][7:0] ain_i,
    output logic [1:0] channel_o,
    output logic [7:0] result_o,
    output logic converting_o,
    output logic port_ready_o
);
    logic cs_lvl, cs_rise, cs_fall;
    logic sck_rise, si_lvl, cclk_rise;

    sadc_sync_edge u_cs (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .d_i(link.cs),
        .lvl_o(cs_lvl), .rise_o(cs_rise), .fall_o(cs_fall));
    sadc_sync_edge u_sck (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .d_i(link.sck),
        .lvl_o(), .rise_o(sck_rise), .fall_o());
    sadc_sync_edge u_si (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .d_i(link.si),
        .lvl_o(si_lvl), .rise_o(), .fall_o());
    sadc_sync_edge u_cclk (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .d_i(link.conv_clk),
        .lvl_o(), .rise_o(cclk_rise), .fall_o());

    sadc_dev_state_t st_reg, st_next;
    logic [7:0] sr_reg, sr_next;
    logic [7:0] trial_reg, trial_next;
    logic [7:0] res_reg, res_next;
    logic [2:0] idx_reg, idx_next;
    logic [2:0] sub_reg, sub_next;
    logic [2:0] dly_reg, dly_next;
    logic [1:0] ch_reg, ch_next;
    logic so_reg, so_next;
    logic [7:0] kept;

    // ------------------------------------------------------------
    // Sequence controller
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        sr_next = sr_reg;
        trial_next = trial_reg;
        res_next = res_reg;
        idx_next = idx_reg;
        sub_next = sub_reg;
        dly_next = dly_reg;
        ch_next = ch_reg;
        so_next = so_reg;
        kept = trial_reg;
        // Drop the trial bit when the trial voltage exceeds the input
        if (trial_reg > ain_i[ch_reg]) begin
            kept[idx_reg] = 1'b0;
        end
        case (st_reg)
            DEV_PORT: begin
                if (cs_rise) begin
                    ch_next = sr_reg[1:0];
                    trial_next = SAR_FIRST;
                    idx_next = 3'(SAR_BITS - 1);
                    sub_next = 3'h0;
                    st_next = DEV_CONV;
                end else if (sck_rise && !cs_lvl) begin
                    so_next = sr_reg[7];
                    sr_next = {sr_reg[6:0], si_lvl};
                end
            end
            DEV_CONV: begin
                if (cs_fall) begin
                    dly_next = 3'h0;
                    st_next = DEV_DRAIN;
                end else if (cclk_rise) begin
                    sub_next = sub_reg + 3'h1;
                    if (sub_reg == 3'(CLK_PER_BIT - 1)) begin
                        sub_next = 3'h0;
                        if (idx_reg == 3'h0) begin
                            res_next = kept;
                            trial_next = SAR_FIRST;
                            idx_next = 3'(SAR_BITS - 1);
                        end else begin
                            trial_next = kept;
                            trial_next[idx_reg - 3'h1] = 1'b1;
                            idx_next = idx_reg - 3'h1;
                        end
                    end
                end
            end
            DEV_DRAIN: begin
                if (cs_rise) begin
                    trial_next = SAR_FIRST;
                    idx_next = 3'(SAR_BITS - 1);
                    sub_next = 3'h0;
                    st_next = DEV_CONV;
                end else if (cclk_rise) begin
                    dly_next = dly_reg + 3'h1;
                    if (dly_reg == 3'(PORT_DELAY_CLKS - 1)) begin
                        sr_next = res_reg;
                        st_next = DEV_PORT;
                    end
                end
            end
            default: begin
                st_next = DEV_PORT;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= DEV_PORT;
            sr_reg <= 8'h00;
            trial_reg <= 8'h00;
            res_reg <= 8'h00;
            idx_reg <= 3'h0;
            sub_reg <= 3'h0;
            dly_reg <= 3'h0;
            ch_reg <= 2'h0;
            so_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            sr_reg <= sr_next;
            trial_reg <= trial_next;
            res_reg <= res_next;
            idx_reg <= idx_next;
            sub_reg <= sub_next;
            dly_reg <= dly_next;
            ch_reg <= ch_next;
            so_reg <= so_next;
        end
    end

    assign link.so = so_reg;
    assign channel_o = ch_reg;
    assign result_o = res_reg;
    assign converting_o = (st_reg == DEV_CONV);
    assign port_ready_o = (st_reg == DEV_PORT);
endmodule

// File: hw/sadc_host_end.sv
// Controller end: channel select, conversion hold, readout, battery checks
`timescale 1ns/10ps
module sadc_host_end
    import sadc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    sadc_link_if.host link,
    input wire logic start_i,
    input wire logic [1:0] chan_i,
    input wire logic adapter_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] result_o,
    output logic low_batt_o,
    output logic recharge_o,
    output logic aux_switch_o,
    output logic charge_normal_o
);
    logic so_lvl;

    sadc_sync_edge u_so (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .d_i(link.so),
        .lvl_o(so_lvl),
        .rise_o(),
        .fall_o()
    );

    // ------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------
    logic [3:0] cdiv_reg, cdiv_next;
    logic cclk_reg, cclk_next;

    always_comb begin
        cdiv_next = cdiv_reg + 4'h1;
        cclk_next = cclk_reg;
        if (cdiv_reg == 4'(CONV_HALF - 1)) begin
            cdiv_next = 4'h0;
            cclk_next = ~cclk_reg;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cdiv_reg <= 4'h0;
            cclk_reg <= 1'b0;
        end else begin
            cdiv_reg <= cdiv_next;
            cclk_reg <= cclk_next;
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    sadc_host_state_t st_reg, st_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [2:0] half_reg, half_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sr_reg, sr_next;
    logic [7:0] res_reg, res_next;
    logic [1:0] ch_reg, ch_next;
    logic cs_reg, cs_next;
    logic sck_reg, sck_next;
    logic si_reg, si_next;
    logic done_reg, done_next;
    logic low_reg, low_next;
    logic rech_reg, rech_next;
    logic aux_reg, aux_next;
    logic chg_reg, chg_next;
    logic half_end;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        half_next = half_reg;
        bit_next = bit_reg;
        sr_next = sr_reg;
        res_next = res_reg;
        ch_next = ch_reg;
        cs_next = cs_reg;
        sck_next = sck_reg;
        si_next = si_reg;
        done_next = 1'b0;
        low_next = low_reg;
        rech_next = rech_reg;
        aux_next = aux_reg;
        chg_next = chg_reg;
        half_end = (half_reg == 3'(SCK_HALF - 1));
        case (st_reg)
            H_IDLE: begin
                if (start_i) begin
                    ch_next = chan_i;
                    sr_next = {6'h00, chan_i};
                    si_next = 1'b0;
                    cs_next = 1'b0;
                    sck_next = 1'b0;
                    half_next = 3'h0;
                    bit_next = 4'h0;
                    st_next = H_SEL;
                end
            end
            H_SEL: begin
                half_next = half_reg + 3'h1;
                if (half_end) begin
                    half_next = 3'h0;
                    if (!sck_reg) begin
                        sck_next = 1'b1;
                    end else begin
                        sck_next = 1'b0;
                        bit_next = bit_reg + 4'h1;
                        sr_next = {sr_reg[6:0], 1'b0};
                        si_next = sr_reg[6];
                        if (bit_reg == 4'(ADDR_BITS - 1)) begin
                            cs_next = 1'b1;
                            si_next = 1'b0;
                            cnt_next = '0;
                            st_next = H_CONV;
                        end
                    end
                end else if (!sck_reg) begin
                    si_next = sr_reg[7];
                end
            end
            H_CONV: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == CNT_W'(CONV_HOLD_CYC - 1)) begin
                    cs_next = 1'b0;
                    cnt_next = '0;
                    st_next = H_WAIT;
                end
            end
            H_WAIT: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == CNT_W'(PORT_WAIT_CYC - 1)) begin
                    half_next = 3'h0;
                    bit_next = 4'h0;
                    st_next = H_READ;
                end
            end
            H_READ: begin
                half_next = half_reg + 3'h1;
                if (half_end) begin
                    half_next = 3'h0;
                    if (!sck_reg) begin
                        // Bit of the previous pulse has cleared both synchronisers by now
                        if (bit_reg != 4'h0) begin
                            res_next = {res_reg[6:0], so_lvl};
                        end
                        if (bit_reg == 4'(SAR_BITS)) begin
                            st_next = H_DONE;
                        end else begin
                            sck_next = 1'b1;
                        end
                    end else begin
                        sck_next = 1'b0;
                        bit_next = bit_reg + 4'h1;
                    end
                end
            end
            H_DONE: begin
                done_next = 1'b1;
                if (ch_reg == CH_BATTERY) begin
                    low_next = (res_reg[7:EFF_LSB] <= LOW_VOLT_CODE[7:EFF_LSB]);
                    rech_next = (res_reg[7:EFF_LSB] <= RECHARGE_CODE[7:EFF_LSB]);
                    if (res_reg[7:EFF_LSB] <= LOW_VOLT_CODE[7:EFF_LSB]) begin
                        aux_next = 1'b1;
                    end
                    chg_next = adapter_i && (res_reg[7:EFF_LSB] <= RECHARGE_CODE[7:EFF_LSB]);
                end
                st_next = H_IDLE;
            end
            default: begin
                st_next = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= H_IDLE;
            cnt_reg <= '0;
            half_reg <= 3'h0;
            bit_reg <= 4'h0;
            sr_reg <= 8'h00;
            res_reg <= 8'h00;
            ch_reg <= 2'h0;
            cs_reg <= 1'b0;
            sck_reg <= 1'b0;
            si_reg <= 1'b0;
            done_reg <= 1'b0;
            low_reg <= 1'b0;
            rech_reg <= 1'b0;
            aux_reg <= 1'b0;
            chg_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            half_reg <= half_next;
            bit_reg <= bit_next;
            sr_reg <= sr_next;
            res_reg <= res_next;
            ch_reg <= ch_next;
            cs_reg <= cs_next;
            sck_reg <= sck_next;
            si_reg <= si_next;
            done_reg <= done_next;
            low_reg <= low_next;
            rech_reg <= rech_next;
            aux_reg <= aux_next;
            chg_reg <= chg_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.cs = cs_reg;
    assign link.sck = sck_reg;
    assign link.si = si_reg;
    assign link.conv_clk = cclk_reg;
    assign busy_o = (st_reg != H_IDLE);
    assign done_o = done_reg;
    assign result_o = res_reg;
    assign low_batt_o = low_reg;
    assign recharge_o = rech_reg;
    assign aux_switch_o = aux_reg;
    assign charge_normal_o = chg_reg;
endmodule

// File: verification/sadc_link_asserts.sv
// Concurrent checks on the serial link between controller and converter
`timescale 1ns/10ps
module sadc_link_asserts (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic cs,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic conv_clk
);
    logic cs_q_reg, cs_q_next, sck_q_reg, sck_q_next, cv_q_reg, cv_q_next;
    logic [7:0] cc_cnt_reg, cc_cnt_next, wait_cnt_reg, wait_cnt_next;
    logic [4:0] sck_cnt_reg, sck_cnt_next;

    // ------------------------------------------------------------
    // Edge tracking and counters
    // ------------------------------------------------------------
    always_comb begin
        cs_q_next = cs;
        sck_q_next = sck;
        cv_q_next = conv_clk;
        cc_cnt_next = cc_cnt_reg;
        wait_cnt_next = wait_cnt_reg;
        sck_cnt_next = sck_cnt_reg;
        if (cs && !cs_q_reg) begin
            cc_cnt_next = 8'h00;
        end else if (cs && conv_clk && !cv_q_reg && cc_cnt_reg != 8'hff) begin
            cc_cnt_next = cc_cnt_reg + 8'h01;
        end
        if (!cs && cs_q_reg) begin
            wait_cnt_next = 8'h00;
            sck_cnt_next = 5'h00;
        end else begin
            if (wait_cnt_reg != 8'hff) begin
                wait_cnt_next = wait_cnt_reg + 8'h01;
            end
            if (sck && !sck_q_reg) begin
                sck_cnt_next = sck_cnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_q_reg <= 1'b0;
            sck_q_reg <= 1'b0;
            cv_q_reg <= 1'b0;
            cc_cnt_reg <= 8'h00;
            wait_cnt_reg <= 8'hff;
            sck_cnt_reg <= 5'h00;
        end else begin
            cs_q_reg <= cs_q_next;
            sck_q_reg <= sck_q_next;
            cv_q_reg <= cv_q_next;
            cc_cnt_reg <= cc_cnt_next;
            wait_cnt_reg <= wait_cnt_next;
            sck_cnt_reg <= sck_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_sck_high;
        sck [*4] ##1 !sck;
    endsequence
    sequence s_sck_low;
        !sck [*4];
    endsequence

    a_conv_clk_half: assert property ($rose(conv_clk) |-> ##12 $fell(conv_clk))
        else $error("conversion clock half period wrong");
    a_sck_pulse_high: assert property ($rose(sck) |-> s_sck_high)
        else $error("shift clock high time wrong");
    a_sck_pulse_low: assert property ($fell(sck) |-> s_sck_low)
        else $error("shift clock low time wrong");
    a_si_stable_high: assert property (sck && $past(sck) |-> $stable(si))
        else $error("address data moved while shift clock high");
    a_addr_eight_bits: assert property ($rose(cs) |-> sck_cnt_reg[2:0] == 3'h0 && sck_cnt_reg != 5'h00)
        else $error("shift clock count not a whole byte");
    a_sck_cs_low: assert property (sck |-> !cs)
        else $error("shift clock while converting");
    a_conv_min_hold: assert property ($fell(cs) |-> cc_cnt_reg >= 8'h38)
        else $error("select held high under one conversion");
    a_port_wait: assert property ($rose(sck) |-> wait_cnt_reg >= 8'h7d)
        else $error("shift clock before port ready time");
    a_so_stable_low: assert property ($fell(sck) |=> $stable(so) [*3])
        else $error("result data moved while shift clock low");
endmodule

// File: verification/sadc_link_tb.sv
// Self-checking bench joining controller and converter ends
`timescale 1ns/10ps
module sadc_link_tb;
    import sadc_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic adapter_i = 1'b0;
    logic [1:0] chan_i = 2'h0;
    logic [3:0][7:0] ain_i = '0;
    logic h_busy, h_done, low_batt, recharge, aux_sw, chg_norm, d_conv, d_ready;
    logic [7:0] h_result, d_result, si_sh, so_sh, addr_seen;
    logic [1:0] d_channel;
    logic exp_low = 1'b0, exp_rech = 1'b0, exp_aux = 1'b0, exp_norm = 1'b0;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;

    sadc_link_if link_if();
    sadc_host_end sadc_host_end_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .link(link_if.host),
        .start_i(start_i), .chan_i(chan_i), .adapter_i(adapter_i), .busy_o(h_busy), .done_o(h_done),
        .result_o(h_result), .low_batt_o(low_batt), .recharge_o(recharge), .aux_switch_o(aux_sw),
        .charge_normal_o(chg_norm));
    sadc_device_end sadc_device_end_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .link(link_if.dev),
        .ain_i(ain_i), .channel_o(d_channel), .result_o(d_result), .converting_o(d_conv),
        .port_ready_o(d_ready));
    sadc_link_asserts sadc_link_asserts_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cs(link_if.cs),
        .sck(link_if.sck), .si(link_if.si), .so(link_if.so), .conv_clk(link_if.conv_clk));

    // ------------------------------------------------------------
    // Clock, wire monitors, timeout
    // ------------------------------------------------------------
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    always @(posedge link_if.sck) si_sh <= {si_sh[6:0], link_if.si};
    always @(negedge link_if.sck) so_sh <= {so_sh[6:0], link_if.so};
    always @(posedge link_if.cs) addr_seen <= si_sh;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wait_for(ref logic sig, input logic lvl, input int lim);
        int i;
        i = 0;
        while (sig !== lvl && i < lim) begin
            @(negedge mclk_i);
            i++;
        end
        check({7'h00, sig}, {7'h00, lvl});
    endtask

    // One full select, convert, read cycle; input changes to mid while converting
    task automatic run(input logic [1:0] ch, input logic [7:0] a, input logic [7:0] mid, input logic adp);
        @(negedge mclk_i);
        chan_i = ch;
        ain_i[ch] = a;
        adapter_i = adp;
        start_i = 1'b1;
        @(negedge mclk_i);
        start_i = 1'b0;
        wait_for(link_if.cs, 1'b1, 400);
        repeat (100) @(negedge mclk_i);
        check(addr_seen, {6'h00, ch});
        check({6'h00, d_channel}, {6'h00, ch});
        check({7'h00, d_conv}, 8'h01);
        ain_i[ch] = mid;
        wait_for(link_if.cs, 1'b0, 3000);
        repeat (10) @(negedge mclk_i);
        check({7'h00, d_conv}, 8'h00);
        check({7'h00, d_ready}, 8'h00);
        check(d_result, mid);
        wait_for(h_done, 1'b1, 400);
        check(h_result, mid);
        check(so_sh, mid);
        if (ch == CH_BATTERY) begin
            exp_low = mid[7:2] <= LOW_VOLT_CODE[7:2];
            exp_rech = mid[7:2] <= RECHARGE_CODE[7:2];
            exp_aux = exp_aux | exp_low;
            exp_norm = exp_rech & adp;
        end
        @(negedge mclk_i);
        check({6'h00, h_done, h_busy}, 8'h00);
        check({7'h00, low_batt}, {7'h00, exp_low});
        check({7'h00, recharge}, {7'h00, exp_rech});
        check({7'h00, aux_sw}, {7'h00, exp_aux});
        check({7'h00, chg_norm}, {7'h00, exp_norm});
        check({6'h00, link_if.cs, link_if.sck}, 8'h00);
        check({7'h00, d_ready}, 8'h01);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(negedge mclk_i);
        arst_n_i = 1'b1;
        run(2'h0, 8'h5a, 8'ha5, 1'b0);
        run(2'h1, 8'hff, 8'hff, 1'b1);
        run(2'h2, 8'h3c, 8'h3c, 1'b1);
        run(2'h3, 8'h81, 8'h81, 1'b0);
        run(2'h1, 8'he6, 8'he6, 1'b1);
        run(2'h1, 8'he7, 8'he7, 1'b0);
        run(2'h2, 8'h00, 8'h00, 1'b1);
        run(2'h1, 8'hd9, 8'hd9, 1'b1);
        run(2'h1, 8'hff, 8'hff, 1'b1);
        test_done();
    end
endmodule
